// ===== mseq_sequencer.sv
`timescale 1ns/10ps
// What this block does
// - Store holds 256 words of 56 bits
// - Pointer selects the word read this cycle
// - Bits 8..0 address, bits 9 up control
// - Buffer register captures word, drives datapath
// - Address bits merged with branch modifiers
// - Pointer selects exactly one stored word
// - Buffer address part is the pointer
// - Next address from field plus modifiers
// - One word executes per machine cycle
// - Branch test chooses among successor states
// - Console start enters start sequence
// - Load address done with begin starts
// - Branch affects the word after next
// - Branch ORs condition bits into address
// - Leftmost selected condition has priority, true or not
// - History register captures pointer each clock
module mseq_sequencer
  import mseq_pkg::*;
#(
  parameter logic [MSEQ_DEPTH*MSEQ_WORD_W-1:0] WORD_INIT = '0,
  parameter int                               NCOND     = 4
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic [NCOND-1:0]       branch_test_selector,
  input  wire logic [MSEQ_ADDR_W-1:0] basic_branch_modifier,
  input  wire logic [MSEQ_ADDR_W-1:0] expansion_branch_modifier,
  input  wire logic                   console_start,
  input  wire logic                   load_address_switch_done,
  input  wire logic                   begin_cond,
  output logic      [MSEQ_ADDR_W-1:0] next_microaddress_pointer,
  output logic      [MSEQ_CTRL_W-1:0] control_bits,
  output logic      [MSEQ_ADDR_W-1:0] previous_microaddress_history
);
  typedef enum logic [1:0] {
    MSEQ_ST_RESET = 2'b01,
    MSEQ_ST_RUN   = 2'b10
  } mseq_state_t;

  // Pointer, buffer and history live in one record so they move on one edge
  typedef struct packed {
    mseq_state_t            state;
    logic [MSEQ_ADDR_W-1:0] ptr;
    logic [MSEQ_CTRL_W-1:0] ctrl;
    logic [MSEQ_ADDR_W-1:0] hist;
  } mseq_regs_t;

  mseq_regs_t r;
  mseq_regs_t next_r;
  logic [MSEQ_WORD_W-1:0] rom_word;
  logic [MSEQ_ADDR_W-1:0] branch_bits;
  logic [MSEQ_ADDR_W-1:0] base_addr;
  logic [MSEQ_ADDR_W-1:0] formed_addr;
  logic [MSEQ_CTRL_W-1:0] store_ctrl;

  // Priority pick: lowest index is the leftmost listed condition
  function automatic logic [MSEQ_ADDR_W-1:0] mseq_pick(input logic [NCOND-1:0] sel,
                                                       input logic [MSEQ_ADDR_W-1:0] mods);
    logic [MSEQ_ADDR_W-1:0] res;
    res = '0;
    for (int i = NCOND - 1; i >= 0; i--) begin
      if (sel[i]) begin
        res = mods & MSEQ_ADDR_W'(1 << i);
      end
    end
    return res;
  endfunction : mseq_pick

  // Only eight pointer bits reach the store; the ninth is carried for the history
  // 256 by 56 store
  mseq_rom #(
    .DEPTH     (MSEQ_DEPTH),
    .WIDTH     (MSEQ_WORD_W),
    .WORD_INIT (WORD_INIT)
  ) u_rom (
    .addr (r.ptr[MSEQ_ROM_AW-1:0]),
    .word (rom_word)
  );

  // Selector comes from the word in the buffer while the store already shows the following word;
  // the modified address is loaded with that word, so a test lands on the word after next
  always_comb begin
    branch_bits = mseq_pick(branch_test_selector, basic_branch_modifier | expansion_branch_modifier);
    base_addr   = rom_word[MSEQ_CTRL_LSB-1:MSEQ_ADDR_LSB] & MSEQ_ADDR_MASK;
    formed_addr = base_addr | branch_bits;
    store_ctrl  = rom_word[MSEQ_WORD_W-1:MSEQ_CTRL_LSB];
  end

  // Next-state formation for pointer, buffer and history
  always_comb begin
    next_r = r;
    next_r.hist = r.ptr;
    case (r.state)
      MSEQ_ST_RESET: begin
        next_r.state = MSEQ_ST_RUN;
        next_r.ptr   = MSEQ_RESET_ADDR;
        next_r.ctrl  = '0;
      end
      MSEQ_ST_RUN: begin
        next_r.ctrl = store_ctrl;
        if (console_start || (load_address_switch_done && begin_cond)) begin
          next_r.ptr = MSEQ_START_ADDR;
        end else begin
          next_r.ptr = formed_addr;
        end
      end
      default: begin
        next_r.state = MSEQ_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r.state <= MSEQ_ST_RESET;
      r.ptr   <= MSEQ_RESET_ADDR;
      r.ctrl  <= '0;
      r.hist  <= MSEQ_RESET_ADDR;
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    next_microaddress_pointer     = r.ptr;
    control_bits                  = r.ctrl;
    previous_microaddress_history = r.hist;
  end

  // Ordinary successor cycle: running, no start entry pending
  sequence s_plain_run;
    r.state == MSEQ_ST_RUN && !console_start && !(load_address_switch_done && begin_cond);
  endsequence : s_plain_run

  // Two running cycles in a row once reset has gone
  sequence s_run_two;
    r.state == MSEQ_ST_RUN ##1 r.state == MSEQ_ST_RUN;
  endsequence : s_run_two

  a_hist_tracks: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(rst_n) |-> previous_microaddress_history == $past(next_microaddress_pointer))
    else $error("history not equal to previous pointer");

  a_start_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (r.state == MSEQ_ST_RUN && console_start) |=> next_microaddress_pointer == MSEQ_START_ADDR)
    else $error("start did not enter start sequence");

  a_load_begin: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (r.state == MSEQ_ST_RUN && load_address_switch_done && begin_cond)
    |=> next_microaddress_pointer == MSEQ_START_ADDR)
    else $error("load address with begin did not start");

  a_next_addr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (r.state == MSEQ_ST_RUN && !console_start && !(load_address_switch_done && begin_cond))
    |=> next_microaddress_pointer == $past(formed_addr))
    else $error("next address not field or modifiers");

  a_ctrl_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    r.state == MSEQ_ST_RUN |=> control_bits == $past(store_ctrl))
    else $error("control bits not loaded from store");

  a_or_base: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (r.state == MSEQ_ST_RUN && !console_start && !load_address_switch_done)
    |=> (next_microaddress_pointer & $past(base_addr)) == $past(base_addr))
    else $error("base address bits lost");

  a_no_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (r.state == MSEQ_ST_RUN && branch_test_selector == '0 && !console_start && !load_address_switch_done)
    |=> next_microaddress_pointer == $past(base_addr))
    else $error("address modified with no test selected");

  a_reset_run: assert property (@(posedge ref_clk) disable iff (!rst_n)
    r.state == MSEQ_ST_RESET |=> s_run_two)
    else $error("sequencer did not start running");

  a_reset_clear: assert property (@(posedge ref_clk)
    !rst_n |=> (next_microaddress_pointer == MSEQ_RESET_ADDR && control_bits == '0
                && previous_microaddress_history == MSEQ_RESET_ADDR))
    else $error("reset left pointer, buffer or history set");

  a_reset_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    r.state == MSEQ_ST_RESET |=> (next_microaddress_pointer == MSEQ_RESET_ADDR && control_bits == '0))
    else $error("inputs acted on in the first cycle after reset");

  a_prio_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_plain_run ##0 branch_test_selector[0]
    |=> (next_microaddress_pointer | 9'h001) == ($past(base_addr) | 9'h001))
    else $error("later condition applied over the leftmost one");

  a_load_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_plain_run ##0 load_address_switch_done
    |=> next_microaddress_pointer == $past(formed_addr))
    else $error("load address without begin changed the flow");
endmodule : mseq_sequencer

// ===== mseq_pkg.sv
package mseq_pkg;
  localparam int MSEQ_DEPTH      = 256;
  localparam int MSEQ_WORD_W     = 56;
  localparam int MSEQ_ADDR_W     = 9;
  localparam int MSEQ_ROM_AW     = 8;
  localparam int MSEQ_ADDR_LSB   = 0;
  localparam int MSEQ_CTRL_LSB   = 9;
  localparam int MSEQ_CTRL_W     = MSEQ_WORD_W - MSEQ_CTRL_LSB;
  localparam logic [8:0] MSEQ_RESET_ADDR = 9'h000;
  localparam logic [8:0] MSEQ_START_ADDR = 9'h01A;
  localparam logic [8:0] MSEQ_ADDR_MASK  = 9'h0FF;
endpackage : mseq_pkg

// ===== mseq_rom.sv
`timescale 1ns/10ps
// Read-only control store; contents come from the word_init parameter
module mseq_rom
  import mseq_pkg::*;
#(
  parameter int                               DEPTH  = MSEQ_DEPTH,
  parameter int                               WIDTH  = MSEQ_WORD_W,
  parameter logic [DEPTH*WIDTH-1:0]            WORD_INIT = '0
) (
  input  wire logic [MSEQ_ROM_AW-1:0] addr,
  output logic      [WIDTH-1:0]       word
);
  // Asynchronous read so the word is ready within the current machine cycle
  always_comb begin
    word = WORD_INIT[addr*WIDTH +: WIDTH];
  end
endmodule : mseq_rom

// ===== mseq_partner.sv
`timescale 1ns/10ps
// Branch condition source on the datapath side of the sequencer
module mseq_partner
  import mseq_pkg::*;
(
  input  wire logic [MSEQ_CTRL_W-1:0] control_bits,
  input  wire logic [MSEQ_ADDR_W-1:0] cond_basic,
  input  wire logic [MSEQ_ADDR_W-1:0] cond_exp,
  output logic      [3:0]             branch_test_selector,
  output logic      [MSEQ_ADDR_W-1:0] basic_branch_modifier,
  output logic      [MSEQ_ADDR_W-1:0] expansion_branch_modifier
);
  // Test field of the word now in the buffer picks the condition at once;
  // the sequencer loads the modified address with the following word, so the branch lands after next
  always_comb begin
    branch_test_selector      = control_bits[3:0];
    basic_branch_modifier     = cond_basic;
    expansion_branch_modifier = cond_exp;
  end
endmodule : mseq_partner

// ===== test_microprogram_sequencer.sv
`timescale 1ns/10ps
// Self-checking bench: a cycle reference runs beside the sequencer
module test_microprogram_sequencer;
  import mseq_pkg::*;
  logic        ref_clk = 1'b0, rst_n = 1'b0, con_st = 1'b0, ld_done = 1'b0, beg = 1'b0, running;
  logic [8:0]  cb = 9'h000, ce = 9'h000, bm, em, ptr, hist, e_ptr, e_hist;
  logic [3:0]  sel;
  logic [46:0] ctrl, e_ctrl;
  logic [55:0] e_word;
  int          fails = 0, cmp_count = 0;
  // Word a: control field depends on a, next field is a plus four
  function automatic logic [55:0] rom_word(input logic [7:0] v);
    return {v ^ 8'hA5, 31'h0000_0000, v, 1'b0, v + 8'h04};
  endfunction : rom_word
  function automatic logic [MSEQ_DEPTH*MSEQ_WORD_W-1:0] rom_image();
    for (int a = 0; a < MSEQ_DEPTH; a++) rom_image[a*MSEQ_WORD_W +: MSEQ_WORD_W] = rom_word(a[7:0]);
  endfunction : rom_image
  localparam logic [MSEQ_DEPTH*MSEQ_WORD_W-1:0] ROM_IMG = rom_image();
  function automatic logic [8:0] next_of(input logic [8:0] p, input logic [3:0] s, input logic [8:0] m);
    logic [55:0] w;
    w = rom_word(p[7:0]);
    for (int i = 0; i < 4; i++) if (s[i]) return (w[8:0] & MSEQ_ADDR_MASK) | (m & (9'h001 << i));
    return w[8:0] & MSEQ_ADDR_MASK;
  endfunction : next_of
  mseq_sequencer #(.WORD_INIT(ROM_IMG), .NCOND(4)) mseq_sequencer_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .branch_test_selector(sel), .basic_branch_modifier(bm), .expansion_branch_modifier(em),
    .console_start(con_st), .load_address_switch_done(ld_done), .begin_cond(beg),
    .next_microaddress_pointer(ptr), .control_bits(ctrl), .previous_microaddress_history(hist));
  mseq_partner mseq_partner_i (.control_bits(ctrl), .cond_basic(cb), .cond_exp(ce),
    .branch_test_selector(sel), .basic_branch_modifier(bm), .expansion_branch_modifier(em));
  always #12.5 ref_clk = ~ref_clk;
  // Reference: idle edge after reset, then one word per edge
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      running = 1'b0; e_ptr = 9'h000; e_ctrl = '0; e_hist = 9'h000;
    end else if (!running) running = 1'b1;
    else begin
      e_word = rom_word(e_ptr[7:0]);
      e_hist = e_ptr;
      // test of the running word modifies the address loaded with the next word
      e_ptr = (con_st || (ld_done && beg)) ? MSEQ_START_ADDR : next_of(e_ptr, e_ctrl[3:0], cb | ce);
      e_ctrl = e_word[55:9];
    end
  end
  task automatic check(input string what, input logic [46:0] seen, input logic [46:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++; $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Compare every settled cycle
  always @(negedge ref_clk) begin
    check("pointer", {38'h0, ptr}, {38'h0, e_ptr});
    check("control", ctrl, e_ctrl);
    check("history", {38'h0, hist}, {38'h0, e_hist});
  end
  task automatic step(input string name, input logic [8:0] b, input logic [8:0] e, input logic [2:0] s, int n);
    @(posedge ref_clk); cb <= b; ce <= e; {con_st, ld_done, beg} <= s;
    @(posedge ref_clk); {con_st, ld_done, beg} <= 3'b000;
    repeat (n) @(posedge ref_clk);
    $display("%s done, mismatches %0d", name, fails);
  endtask : step
  task automatic t_reset();
    @(posedge ref_clk); rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk); rst_n <= 1'b1;
    repeat (20) @(posedge ref_clk);
    $display("mid reset done, mismatches %0d", fails);
  endtask : t_reset
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  initial begin
    #(25ns * 4000); fails++; complete_run();
  end
  initial begin
    repeat (12) @(posedge ref_clk); rst_n <= 1'b1;
    step("plain", 9'h000, 9'h000, 3'b000, 64);
    step("basic branch", 9'h1FF, 9'h000, 3'b000, 64);
    step("expansion", 9'h000, 9'h00A, 3'b000, 64);
    step("console start", 9'h000, 9'h000, 3'b100, 8);
    step("load no begin", 9'h000, 9'h000, 3'b010, 8);
    step("load begin", 9'h003, 9'h000, 3'b011, 8);
    t_reset();
    complete_run();
  end
endmodule : test_microprogram_sequencer
